//--- inc/sicd_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants and types of the input command decoder
// ****************************************************************
package sicd_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 32;
  localparam int SET_W     = 16;
  localparam int CNT_W     = 16;
  localparam int NUM_IN    = 9;
  localparam int NUM_SPEED = 7;
  localparam int NUM_GEAR  = 4;
  localparam int SEL_W     = 3;
  localparam int GEAR_W    = 2;

  // ****************************************************************
  // Register offsets (word index on the register port)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL       = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 5'h01;
  localparam logic [ADDR_W-1:0] REG_INPUTS     = 5'h02;
  localparam logic [ADDR_W-1:0] REG_CLEARS     = 5'h03;
  localparam logic [ADDR_W-1:0] REG_SPEED_BASE = 5'h08;
  localparam logic [ADDR_W-1:0] REG_GEAR_BASE  = 5'h10;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_MSB  = 1;
  localparam int CTRL_LEVEL_CLR = 2;
  localparam int CTRL_SP3_EN    = 3;
  localparam int CTRL_GEAR_EN   = 4;
  localparam int CTRL_GAIN_EN   = 5;
  localparam int CTRL_ABS_SYS   = 6;
  localparam int CTRL_W         = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int STAT_HALT      = 0;
  localparam int STAT_ANALOG    = 1;
  localparam int STAT_PROP      = 2;
  localparam int STAT_GAIN_ALT  = 3;
  localparam int STAT_CLEARING  = 4;
  localparam int STAT_SEL_LSB   = 8;
  localparam int STAT_GEAR_LSB  = 12;

  // ****************************************************************
  // Filtered input bit positions
  // ****************************************************************
  localparam int IN_SP0  = 0;
  localparam int IN_SP1  = 1;
  localparam int IN_SP2  = 2;
  localparam int IN_PROP = 3;
  localparam int IN_EMG  = 4;
  localparam int IN_CLR  = 5;
  localparam int IN_CM0  = 6;
  localparam int IN_CM1  = 7;
  localparam int IN_GAIN = 8;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 200;
  localparam int DEBOUNCE_US   = 100;
  localparam int DROOP_MIN_MS  = 10;
  localparam logic [CNT_W-1:0] DEBOUNCE_CYCLES_DEF =
    CNT_W'(DEBOUNCE_US * CLK_MHZ);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_POS    = 2'b00,
    MODE_SPEED  = 2'b01,
    MODE_TORQUE = 2'b10
  } sicd_mode_t;

  typedef enum logic {
    HALT_RUN  = 1'b0,
    HALT_STOP = 1'b1
  } sicd_halt_t;

endpackage
`default_nettype wire

//--- logic/sicd_input_filter.sv
`timescale 1ns/100ps
`default_nettype none
module sicd_input_filter #(
  parameter logic [sicd_pkg::CNT_W-1:0] LIMIT = sicd_pkg::DEBOUNCE_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  // Raw pins
  input  wire logic [sicd_pkg::NUM_IN-1:0] raw,
  // Filtered levels
  output logic      [sicd_pkg::NUM_IN-1:0] stable
);
  import sicd_pkg::*;

  logic [NUM_IN-1:0] meta;
  logic [NUM_IN-1:0] sync;
  logic [CNT_W-1:0]  cnt [NUM_IN];

  // ****************************************************************
  // Two-flop synchroniser
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  // ****************************************************************
  // Stability counters
  // ****************************************************************
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (!reset_n) begin
        cnt[i] <= '0;
      end else if (sync[i] == stable[i]) begin
        cnt[i] <= '0;
      end else if (cnt[i] >= LIMIT - CNT_W'(1)) begin
        cnt[i] <= '0;
      end else begin
        cnt[i] <= cnt[i] + CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // Accepted level
  // ****************************************************************
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (!reset_n) begin
        stable[i] <= 1'b0;
      end else if (sync[i] != stable[i] && cnt[i] >= LIMIT - CNT_W'(1)) begin
        stable[i] <= sync[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/sicd_decoder.sv
// Contract
// [R1] Speed mode: code 0 picks the analog reference, 1..7 a stored setting.
// [R2] Torque mode: code 0 picks the analog ceiling, 1..7 a stored limit.
// [R3] The top speed-select bit counts only when enabled, else it reads as off.
// [R4] While proportional-only is on, the speed loop is proportional only.
// [R5] Emergency-halt off enters stop: base drive off, dynamic brake on.
// [R6] Emergency-halt back on leaves the stop state.
// [R7] In position mode a rising edge of droop-clear clears the droop counter.
// [R8] The controller holds droop-clear on for at least 10 ms per request; the bench model holds it HOLD = 20 cycles past the last request cycle.
// [R9] A droop clear also flushes the pending command smoothing delay.
// [R10] In level-clear mode the droop counter stays cleared while input is on.
// [R11] Gear code 00 picks the base numerator, 01, 10, 11 the second to fourth.
// [R12] With the absolute position system in use the gear inputs are ignored.
// [R13] While gain-switch is on the alternate gain set is selected.
// [R14] Gain-switch and gear inputs act only when enabled.
// [R15] Every discrete input is synchronised and debounced before decoding.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sicd_decoder #(
  parameter logic [sicd_pkg::CNT_W-1:0] DEBOUNCE_CYCLES =
    sicd_pkg::DEBOUNCE_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  // Discrete inputs from the controller
  input  wire logic                          speed_select_bit0,
  input  wire logic                          speed_select_bit1,
  input  wire logic                          speed_select_bit2,
  input  wire logic                          proportional_only_request,
  input  wire logic                          emergency_halt_input,
  input  wire logic                          droop_clear_input,
  input  wire logic                          gear_select_bit0,
  input  wire logic                          gear_select_bit1,
  input  wire logic                          gain_switch_input,
  // Register port
  input  wire logic [sicd_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [sicd_pkg::DATA_W-1:0]   reg_wr_data,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [sicd_pkg::DATA_W-1:0]   reg_rd_data,
  // Speed command selection
  output logic                               select_analog_speed_reference,
  output logic                               select_analog_speed_ceiling,
  output logic      [sicd_pkg::SEL_W-1:0]    speed_setting_index,
  output logic      [sicd_pkg::SET_W-1:0]    speed_setting_value,
  output logic                               speed_value_is_limit,
  // Loop and gain control
  output logic                               loop_proportional_only,
  output logic                               gain_set_alternate,
  // Power stage
  output logic                               base_drive_enable,
  output logic                               dynamic_brake_on,
  // Position counter control
  output logic                               droop_clear,
  output logic                               smoothing_flush,
  // Electronic gear
  output logic      [sicd_pkg::GEAR_W-1:0]   gear_index,
  output logic      [sicd_pkg::SET_W-1:0]    gear_numerator
);
  import sicd_pkg::*;

  // ********************
  // Helpers
  // ********************
  function automatic logic sicd_gate(input logic level, input logic enable);
    sicd_gate = level & enable;
  endfunction

  function automatic logic sicd_in_window(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] base,
    input int                count
  );
    logic [ADDR_W-1:0] off;
    off = addr - base;
    sicd_in_window = (addr >= base) && (off < ADDR_W'(count));
  endfunction

  // ********************
  // Declarations
  // ********************
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] filt;
  logic [CTRL_W-1:0] ctrl;
  logic [SET_W-1:0]  speed_set [NUM_SPEED];
  logic [SET_W-1:0]  gear_set  [NUM_GEAR];
  logic [DATA_W-1:0] clear_count;
  logic              clr_prev;
  sicd_halt_t        halt_state;
  sicd_halt_t        next_halt_state;
  sicd_mode_t        mode;
  logic [SEL_W-1:0]  next_sel;
  logic [GEAR_W-1:0] next_gear;
  logic              next_clear;
  logic [ADDR_W-1:0] speed_off;
  logic [ADDR_W-1:0] gear_off;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] next_rd_data;

  // ********************
  // Input conditioning
  // ********************
  always_comb begin
    raw_in          = '0;
    raw_in[IN_SP0]  = speed_select_bit0;
    raw_in[IN_SP1]  = speed_select_bit1;
    raw_in[IN_SP2]  = speed_select_bit2;
    raw_in[IN_PROP] = proportional_only_request;
    raw_in[IN_EMG]  = emergency_halt_input;
    raw_in[IN_CLR]  = droop_clear_input;
    raw_in[IN_CM0]  = gear_select_bit0;
    raw_in[IN_CM1]  = gear_select_bit1;
    raw_in[IN_GAIN] = gain_switch_input;
  end

  sicd_input_filter #(
    .LIMIT (DEBOUNCE_CYCLES)
  ) u_filter (
    .mclk    (mclk),
    .reset_n (reset_n),
    .raw     (raw_in),
    .stable  (filt)
  ); // [R15]

  // ********************
  // Operating mode
  // ********************
  always_comb begin
    case (ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB])
      MODE_SPEED:  mode = MODE_SPEED;
      MODE_TORQUE: mode = MODE_TORQUE;
      default:     mode = MODE_POS;
    endcase
  end

  // ********************
  // Register writes
  // ********************
  assign speed_off = reg_addr - REG_SPEED_BASE;
  assign gear_off  = reg_addr - REG_GEAR_BASE;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl <= reg_wr_data[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_SPEED; i++) begin
      if (!reset_n) begin
        speed_set[i] <= '0;
      end else if (reg_wr && sicd_in_window(reg_addr, REG_SPEED_BASE,
                                            NUM_SPEED)
                   && speed_off == ADDR_W'(i)) begin
        speed_set[i] <= reg_wr_data[SET_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_GEAR; i++) begin
      if (!reset_n) begin
        gear_set[i] <= '0;
      end else if (reg_wr && sicd_in_window(reg_addr, REG_GEAR_BASE,
                                            NUM_GEAR)
                   && gear_off == ADDR_W'(i)) begin
        gear_set[i] <= reg_wr_data[SET_W-1:0];
      end
    end
  end

  // ********************
  // Speed command and speed limit selection
  // ********************
  always_comb begin
    next_sel = {sicd_gate(filt[IN_SP2], ctrl[CTRL_SP3_EN]),
                filt[IN_SP1], filt[IN_SP0]}; // [R3]
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      select_analog_speed_reference <= 1'b0;
      select_analog_speed_ceiling   <= 1'b0;
      speed_setting_index           <= '0;
      speed_setting_value           <= '0;
      speed_value_is_limit          <= 1'b0;
    end else begin
      speed_setting_index <= next_sel;
      select_analog_speed_reference <=
        (mode == MODE_SPEED) && (next_sel == '0); // [R1]
      select_analog_speed_ceiling <=
        (mode == MODE_TORQUE) && (next_sel == '0); // [R2]
      speed_value_is_limit <= (mode == MODE_TORQUE); // [R2]
      if (mode != MODE_POS && next_sel != '0) begin
        speed_setting_value <= speed_set[next_sel - SEL_W'(1)]; // [R1] [R2]
      end else begin
        speed_setting_value <= '0;
      end
    end
  end

  // ********************
  // Loop type and gain set
  // ********************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      loop_proportional_only <= 1'b0;
      gain_set_alternate     <= 1'b0;
    end else begin
      loop_proportional_only <= filt[IN_PROP]; // [R4]
      gain_set_alternate <=
        sicd_gate(filt[IN_GAIN], ctrl[CTRL_GAIN_EN]); // [R13] [R14]
    end
  end

  // ********************
  // Emergency stop state
  // ********************
  always_comb begin
    case (halt_state)
      HALT_RUN: begin
        if (!filt[IN_EMG]) begin
          next_halt_state = HALT_STOP; // [R5]
        end else begin
          next_halt_state = HALT_RUN;
        end
      end
      HALT_STOP: begin
        if (filt[IN_EMG]) begin
          next_halt_state = HALT_RUN; // [R6]
        end else begin
          next_halt_state = HALT_STOP;
        end
      end
      default: next_halt_state = HALT_STOP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      halt_state        <= HALT_STOP;
      base_drive_enable <= 1'b0;
      dynamic_brake_on  <= 1'b1;
    end else begin
      halt_state        <= next_halt_state;
      base_drive_enable <= (next_halt_state == HALT_RUN); // [R5] [R6]
      dynamic_brake_on  <= (next_halt_state == HALT_STOP); // [R5]
    end
  end

  // ********************
  // Droop counter clear
  // ********************
  always_comb begin
    if (mode != MODE_POS) begin
      next_clear = 1'b0;
    end else if (ctrl[CTRL_LEVEL_CLR]) begin
      next_clear = filt[IN_CLR]; // [R10]
    end else begin
      next_clear = filt[IN_CLR] & ~clr_prev; // [R7]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clr_prev        <= 1'b0;
      droop_clear     <= 1'b0;
      smoothing_flush <= 1'b0;
    end else begin
      clr_prev        <= filt[IN_CLR];
      droop_clear     <= next_clear; // [R7] [R10]
      smoothing_flush <= next_clear; // [R9]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clear_count <= '0;
    end else if (reg_wr && reg_addr == REG_CLEARS) begin
      clear_count <= '0;
    end else if (next_clear) begin
      clear_count <= clear_count + DATA_W'(1);
    end
  end

  // ********************
  // Electronic gear selection
  // ********************
  always_comb begin
    if (ctrl[CTRL_GEAR_EN] && !ctrl[CTRL_ABS_SYS]) begin
      next_gear = {filt[IN_CM1], filt[IN_CM0]}; // [R11] [R14]
    end else begin
      next_gear = '0; // [R12]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gear_index     <= '0;
      gear_numerator <= '0;
    end else begin
      gear_index     <= next_gear;
      gear_numerator <= gear_set[next_gear]; // [R11]
    end
  end

  // ********************
  // Status word
  // ********************
  always_comb begin
    status_word                 = '0;
    status_word[STAT_HALT]      = (halt_state == HALT_STOP);
    status_word[STAT_ANALOG]    = select_analog_speed_reference
                                  | select_analog_speed_ceiling;
    status_word[STAT_PROP]      = loop_proportional_only;
    status_word[STAT_GAIN_ALT]  = gain_set_alternate;
    status_word[STAT_CLEARING]  = droop_clear;
    status_word[STAT_SEL_LSB +: SEL_W]   = speed_setting_index;
    status_word[STAT_GEAR_LSB +: GEAR_W] = gear_index;
  end

  // ********************
  // Register reads
  // ********************
  always_comb begin
    next_rd_data = '0;
    if (reg_addr == REG_CTRL) begin
      next_rd_data[CTRL_W-1:0] = ctrl;
    end else if (reg_addr == REG_STATUS) begin
      next_rd_data = status_word;
    end else if (reg_addr == REG_INPUTS) begin
      next_rd_data[NUM_IN-1:0] = filt;
    end else if (reg_addr == REG_CLEARS) begin
      next_rd_data = clear_count;
    end else if (sicd_in_window(reg_addr, REG_SPEED_BASE, NUM_SPEED)) begin
      next_rd_data[SET_W-1:0] = speed_set[speed_off[SEL_W-1:0]];
    end else if (sicd_in_window(reg_addr, REG_GEAR_BASE, NUM_GEAR)) begin
      next_rd_data[SET_W-1:0] = gear_set[gear_off[GEAR_W-1:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd) begin
      reg_rd_data <= next_rd_data;
    end else begin
      reg_rd_data <= '0;
    end
  end

endmodule
`default_nettype wire

//--- bench/sicd_decoder_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sicd_decoder_properties #(
  parameter logic [sicd_pkg::CNT_W-1:0] DEBOUNCE_CYCLES = 16'h0004
) (
  // Clock and reset
  input wire logic                        mclk,
  input wire logic                        reset_n,
  // Discrete pins
  input wire logic                        emergency_halt_input,
  input wire logic                        proportional_only_request,
  input wire logic                        droop_clear_input,
  input wire logic                        gear_select_bit1,
  input wire logic                        gain_switch_input,
  // Decoded outputs
  input wire logic                        select_analog_speed_reference,
  input wire logic                        select_analog_speed_ceiling,
  input wire logic [sicd_pkg::SEL_W-1:0]  speed_setting_index,
  input wire logic [sicd_pkg::SET_W-1:0]  speed_setting_value,
  input wire logic                        speed_value_is_limit,
  input wire logic                        loop_proportional_only,
  input wire logic                        gain_set_alternate,
  input wire logic                        base_drive_enable,
  input wire logic                        dynamic_brake_on,
  input wire logic                        droop_clear,
  input wire logic                        smoothing_flush,
  input wire logic [sicd_pkg::GEAR_W-1:0] gear_index
);
  import sicd_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_brake_inverse;
    base_drive_enable != dynamic_brake_on;
  endproperty
  a_brake_inverse: assert property (p_brake_inverse)
    else $error("base drive and brake not complementary");
  property p_halt_enter;
    (!emergency_halt_input) [*8] |-> ##[0:3] dynamic_brake_on;
  endproperty
  a_halt_enter: assert property (p_halt_enter)
    else $error("halt input off but brake not applied");
  property p_halt_leave;
    emergency_halt_input [*8] |-> ##[0:3] base_drive_enable;
  endproperty
  a_halt_leave: assert property (p_halt_leave)
    else $error("halt input on but stop state kept");
  property p_reference;
    select_analog_speed_reference |-> speed_setting_index == 3'h0 &&
      speed_setting_value == 16'h0000 && !speed_value_is_limit;
  endproperty
  a_reference: assert property (p_reference)
    else $error("analog reference chosen with nonzero code");
  property p_ceiling;
    select_analog_speed_ceiling |-> speed_value_is_limit &&
      speed_setting_index == 3'h0 && !select_analog_speed_reference;
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("analog ceiling chosen outside torque code zero");
  property p_flush;
    smoothing_flush == droop_clear;
  endproperty
  a_flush: assert property (p_flush)
    else $error("smoothing flush differs from droop clear");
  property p_clear_cause;
    $rose(droop_clear) |-> $past(droop_clear_input, 5);
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("droop clear without clear input");
  property p_prop;
    $rose(loop_proportional_only) |-> $past(proportional_only_request, 5);
  endproperty
  a_prop: assert property (p_prop)
    else $error("proportional loop without request");
  property p_gain;
    $rose(gain_set_alternate) |-> $past(gain_switch_input, 5);
  endproperty
  a_gain: assert property (p_gain)
    else $error("alternate gain without switch input");
  property p_gear;
    $rose(gear_index[1]) |-> $past(gear_select_bit1, 5);
  endproperty
  a_gear: assert property (p_gear)
    else $error("gear index high bit without input");
endmodule
`default_nettype wire

//--- bench/sicd_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sicd_ctrl_model #(
  parameter int HOLD = 20
) (
  // Clock
  input  wire logic                        mclk,
  // Commands from the bench
  input  wire logic [sicd_pkg::NUM_IN-1:0] cmd,
  // Discrete pins
  output wire logic                        speed_select_bit0,
  output wire logic                        speed_select_bit1,
  output wire logic                        speed_select_bit2,
  output wire logic                        proportional_only_request,
  output wire logic                        emergency_halt_input,
  output wire logic                        droop_clear_input,
  output wire logic                        gear_select_bit0,
  output wire logic                        gear_select_bit1,
  output wire logic                        gain_switch_input
);
  import sicd_pkg::*;
  logic [7:0]        hold_cnt = 8'h00;
  logic [NUM_IN-1:0] pin_q    = 9'h000;
  // Clear request stretched to the minimum hold
  always @(posedge mclk) begin
    if (cmd[IN_CLR]) begin
      hold_cnt <= 8'(HOLD);
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
    pin_q <= {cmd[8:6], cmd[IN_CLR] | (hold_cnt != 8'h00), cmd[4:0]};
  end
  assign {gain_switch_input, gear_select_bit1, gear_select_bit0,
          droop_clear_input, emergency_halt_input, proportional_only_request,
          speed_select_bit2, speed_select_bit1, speed_select_bit0} = pin_q;
endmodule
`default_nettype wire

//--- bench/sicd_decoder_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sicd_decoder_bench;
  import sicd_pkg::*;
  logic                mclk, reset_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wr_data, reg_rd_data;
  logic [NUM_IN-1:0]   cmd;
  wire logic           speed_select_bit0, speed_select_bit1, speed_select_bit2;
  wire logic           proportional_only_request, emergency_halt_input;
  wire logic           droop_clear_input, gear_select_bit0, gear_select_bit1;
  wire logic           gain_switch_input;
  logic                select_analog_speed_reference, speed_value_is_limit;
  logic                select_analog_speed_ceiling, loop_proportional_only;
  logic                gain_set_alternate, base_drive_enable, dynamic_brake_on;
  logic                droop_clear, smoothing_flush;
  logic [SEL_W-1:0]    speed_setting_index;
  logic [SET_W-1:0]    speed_setting_value, gear_numerator;
  logic [GEAR_W-1:0]   gear_index;
  int                  err_count, samples_checked, n;
  sicd_ctrl_model u_ctrl (.*);
  sicd_decoder #(.DEBOUNCE_CYCLES(16'h0004)) uut (.*);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr      <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check_val(reg_rd_data, exp);
  endtask
  task automatic pins(input logic [NUM_IN-1:0] v);
    @(posedge mclk);
    cmd <= v;
    repeat (14) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic speed_case(input logic [2:0] code, input logic lim,
                            input logic [2:0] eff);
    pins({6'h02, code});
    check_val({select_analog_speed_reference, select_analog_speed_ceiling,
               speed_value_is_limit, speed_setting_index, speed_setting_value},
              {!lim && eff == 3'h0, lim && eff == 3'h0, lim, eff,
               eff == 3'h0 ? 16'h0000 : 16'h1000 + 16'(eff)});
  endtask
  task automatic droop_run(output int cnt);
    cnt = 0;
    @(posedge mclk);
    cmd <= 9'h030;
    @(posedge mclk);
    cmd <= 9'h010;
    repeat (60) begin
      @(negedge mclk);
      if (droop_clear === 1'b1 && smoothing_flush === 1'b1) cnt++;
    end
  endtask
  // ****************************************************************
  // Clock, watchdog and sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wr_data, cmd} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(REG_CTRL, 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0001);
    rd(5'h1f, 32'h0000_0000);
    pins(9'h010);
    check_val(base_drive_enable, 1);
    rd(REG_STATUS, 32'h0000_0000);
    pins(9'h000);
    check_val({base_drive_enable, dynamic_brake_on}, 2'b01);
    $display("test halt done");
    for (int i = 1; i < 8; i++) wr(REG_SPEED_BASE + 5'(i - 1), 32'h1000 + i);
    for (int g = 0; g < 4; g++) wr(REG_GEAR_BASE + 5'(g), 32'h2000 + g);
    rd(REG_SPEED_BASE + 5'h06, 32'h0000_1007);
    wr(REG_CTRL, 32'h0000_0009);
    for (int c = 0; c < 8; c++) speed_case(3'(c), 1'b0, 3'(c));
    wr(REG_CTRL, 32'h0000_0001);
    speed_case(3'h4, 1'b0, 3'h0);
    speed_case(3'h5, 1'b0, 3'h1);
    wr(REG_CTRL, 32'h0000_000a);
    for (int c = 0; c < 8; c++) speed_case(3'(c), 1'b1, 3'(c));
    $display("test speed done");
    wr(REG_CTRL, 32'h0000_0010);
    for (int g = 0; g < 4; g++) begin
      pins({1'b0, 2'(g), 6'h10});
      check_val({gear_index, gear_numerator}, {2'(g), 16'h2000 + 16'(g)});
    end
    wr(REG_CTRL, 32'h0000_0050);
    check_val({gear_index, gear_numerator}, {2'h0, 16'h2000});
    wr(REG_CTRL, 32'h0000_0000);
    check_val(gear_index, 0);
    pins(9'h118);
    check_val({gain_set_alternate, loop_proportional_only}, 2'b01);
    rd(REG_INPUTS, 32'h0000_0118);
    wr(REG_CTRL, 32'h0000_0020);
    check_val(gain_set_alternate, 1);
    pins(9'h010);
    check_val({gain_set_alternate, loop_proportional_only}, 2'b00);
    $display("test gear gain done");
    wr(REG_CTRL, 32'h0000_0000);
    droop_run(n);
    check_val(n, 1);
    rd(REG_CLEARS, 32'h0000_0001);
    wr(REG_CLEARS, 32'h0000_0000);
    rd(REG_CLEARS, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0004);
    droop_run(n);
    check_val(n > 10, 1);
    wr(REG_CTRL, 32'h0000_0001);
    droop_run(n);
    check_val(n, 0);
    $display("test droop done");
    end_of_test();
  end
endmodule
bind sicd_decoder sicd_decoder_properties #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_props (.*);
`default_nettype wire
